/* common/vic_cfg.svh */
// Register offsets, bit positions, reset values and vectors of the IRQ block
`ifndef VIC_CFG_SVH
`define VIC_CFG_SVH
`define VIC_OFS_CTRL3 12'h000
`define VIC_OFS_GRP_PLO 12'h004
`define VIC_OFS_GRP_PHI 12'h008
`define VIC_OFS_GRP_CT 12'h00C
`define VIC_OFS_CORE 12'h010
`define VIC_OFS_STATUS 12'h014
`define VIC_RST_REG 8'h00
`define VIC_BIT_UART_F 7
`define VIC_BIT_SER_F 6
`define VIC_BIT_G2_F 5
`define VIC_BIT_G1_F 4
`define VIC_BIT_UART_E 3
`define VIC_BIT_SER_E 2
`define VIC_BIT_G2_E 1
`define VIC_BIT_G1_E 0
`define VIC_BIT_GIE 0
`define VIC_VEC_G1 12'h014
`define VIC_VEC_G2 12'h018
`define VIC_VEC_SER 12'h01C
`define VIC_VEC_UART 12'h020
`endif

/* common/vic_pkg.sv */
// Types shared by the vectored interrupt controller
package vic_pkg;
  typedef logic [7:0] vic_reg_t;
  typedef enum logic [1:0] {
    VIC_SRC_G1,
    VIC_SRC_G2,
    VIC_SRC_SER,
    VIC_SRC_UART
  } vic_src_e;
  typedef enum {
    VIC_RUN,
    VIC_SERVICE
  } vic_state_e;
endpackage

/* src/vic_irq_ctrl.sv */
// Vectored interrupt controller: flags, enables, priority, vectoring, wake
//
// Contract
// - Third control: serial, group2, group1 flags/enables
// - Small variant: bits 7 and 3 read zero
// - Large variant: bit 7 UART flag, bit 3 enable
// - Group low: periodic timers 1/0 flags, enables
// - Group high: periodic timers 3/2 flags, enables
// - Compact group: compact timers 1/0 flags, enables
// - Flag one pending, enable one on, reset zero
// - Source events set flags regardless of enables
// - Disabled source keeps flag, no vector
// - Global enable clear blocks all interrupts
// - Take: push next pc, load vector
// - Return instruction pops saved pc, resumes
// - Taking interrupt clears global enable
// - Requests during service stay pending
// - Stack full blocks acknowledge until pop
// - Fixed priority picks single winning vector
// - Timer sources share group vectors
// - Any flag set raises wake request
// - Any included timer flag sets group flag
// - Group service clears group flag only
// - Own-vector service clears its own flag
`timescale 1ns/1ps
`include "vic_cfg.svh"
module vic_irq_ctrl
  import vic_pkg::*;
#(
  parameter bit LARGE_VARIANT = 1'b1,
  parameter int PC_WIDTH = 12,
  parameter int STACK_DEPTH = 8
) (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [11:0] timerMatch,
  input wire logic serialEvent,
  input wire logic uartEvent,
  input wire logic instrBoundary,
  input wire logic [PC_WIDTH-1:0] nextPc,
  input wire logic returnFromIrq,
  output logic irqTake,
  output logic [PC_WIDTH-1:0] irqVector,
  output logic [PC_WIDTH-1:0] resumePc,
  output logic resumeValid,
  output logic stackFull,
  output logic wakeReq
);
  localparam int SPW = $clog2(STACK_DEPTH + 1);
  // Index width of the stack array; the pointer is wide enough to count to full
  localparam int AW = $clog2(STACK_DEPTH);

  vic_reg_t ctrl3;
  vic_reg_t grpLo;
  vic_reg_t grpHi;
  vic_reg_t grpCt;
  logic globalIrqEnable;
  logic [PC_WIDTH-1:0] stackMem [STACK_DEPTH];
  logic [SPW-1:0] stackPtr;
  vic_state_e state;

  logic wrEn;
  logic rdEn;
  logic addrOk;
  logic [3:0] grpHit;
  logic [2:0] grpNew;
  logic [3:0] req;
  logic [3:0] win;
  logic take;
  logic next_resumeValid;

  // Match bits 11:8 compact, 7:4 periodic 3/2, 3:0 periodic 1/0,
  // each nibble ordered A1,P1,A0,P0 as in the register flag field.
  // Flag set term: event or bus write of one, set wins over clear.
  function automatic vic_reg_t grp_next(vic_reg_t cur, logic [3:0] ev,
                                        logic wr, logic [7:0] wd);
    vic_reg_t v;
    v = wr ? wd : cur;
    v[7:4] = v[7:4] | ev;
    return v;
  endfunction

  // A group flag rises when any member flag rises
  function automatic logic grp_rise(vic_reg_t cur, vic_reg_t nxt);
    return |(nxt[7:4] & ~cur[7:4]);
  endfunction

  assign addrOk = (paddr == `VIC_OFS_CTRL3) || (paddr == `VIC_OFS_GRP_PLO)
    || (paddr == `VIC_OFS_GRP_PHI) || (paddr == `VIC_OFS_GRP_CT)
    || (paddr == `VIC_OFS_CORE) || (paddr == `VIC_OFS_STATUS);
  assign wrEn = psel && penable && pwrite && addrOk && pstrb[0];
  assign rdEn = psel && penable && !pwrite;
  assign pready = psel && penable;
  assign pslverr = psel && penable && !addrOk;

  logic wCtrl3;
  logic wLo;
  logic wHi;
  logic wCt;
  assign wCtrl3 = wrEn && (paddr == `VIC_OFS_CTRL3);
  assign wLo = wrEn && (paddr == `VIC_OFS_GRP_PLO);
  assign wHi = wrEn && (paddr == `VIC_OFS_GRP_PHI);
  assign wCt = wrEn && (paddr == `VIC_OFS_GRP_CT);

  vic_reg_t next_grpLo;
  vic_reg_t next_grpHi;
  vic_reg_t next_grpCt;
  assign next_grpLo = grp_next(grpLo, timerMatch[3:0], wLo, pwdata[7:0]);
  assign next_grpHi = grp_next(grpHi, timerMatch[7:4], wHi, pwdata[7:0]);
  assign next_grpCt = grp_next(grpCt, timerMatch[11:8], wCt, pwdata[7:0]);

  assign grpNew[0] = grp_rise(grpLo, next_grpLo) | grp_rise(grpHi, next_grpHi);
  assign grpNew[1] = grp_rise(grpCt, next_grpCt);
  assign grpNew[2] = 1'b0;

  // group needs an enabled flagged member
  assign grpHit[0] = |(grpLo[7:4] & grpLo[3:0]) | |(grpHi[7:4] & grpHi[3:0]);
  assign grpHit[1] = |(grpCt[7:4] & grpCt[3:0]);
  assign grpHit[3:2] = 2'b00;

  assign req[VIC_SRC_G1] = ctrl3[`VIC_BIT_G1_F] && ctrl3[`VIC_BIT_G1_E]
    && grpHit[0];
  assign req[VIC_SRC_G2] = ctrl3[`VIC_BIT_G2_F] && ctrl3[`VIC_BIT_G2_E]
    && grpHit[1];
  assign req[VIC_SRC_SER] = ctrl3[`VIC_BIT_SER_F] && ctrl3[`VIC_BIT_SER_E];
  assign req[VIC_SRC_UART] = LARGE_VARIANT && ctrl3[`VIC_BIT_UART_F]
    && ctrl3[`VIC_BIT_UART_E];

  assign win = req & (~req + 4'h1);

  assign stackFull = (stackPtr == SPW'(STACK_DEPTH));
  // take only at boundary with global on and room
  assign take = instrBoundary && globalIrqEnable && !stackFull
    && (|req) && !returnFromIrq;

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      ctrl3 <= `VIC_RST_REG;
    end else begin
      vic_reg_t v;
      v = wCtrl3 ? pwdata[7:0] : ctrl3;
      // Service clears are applied before new sets so events win
      if (take) begin
        v = v & ~{win[VIC_SRC_UART], win[VIC_SRC_SER], win[VIC_SRC_G2],
                  win[VIC_SRC_G1], 4'h0};
      end
      v[`VIC_BIT_G1_F] = v[`VIC_BIT_G1_F] | grpNew[0];
      v[`VIC_BIT_G2_F] = v[`VIC_BIT_G2_F] | grpNew[1];
      v[`VIC_BIT_SER_F] = v[`VIC_BIT_SER_F] | serialEvent;
      v[`VIC_BIT_UART_F] = v[`VIC_BIT_UART_F] | uartEvent;
      if (!LARGE_VARIANT) begin
        v[`VIC_BIT_UART_F] = 1'b0;
        v[`VIC_BIT_UART_E] = 1'b0;
      end
      ctrl3 <= v;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      grpLo <= `VIC_RST_REG;
      grpHi <= `VIC_RST_REG;
      grpCt <= `VIC_RST_REG;
    end else begin
      grpLo <= next_grpLo;
      grpHi <= next_grpHi;
      grpCt <= next_grpCt;
    end
  end

  // global enable cleared on take, software may set again
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      globalIrqEnable <= 1'b0;
    end else if (take) begin
      globalIrqEnable <= 1'b0;
    end else if (wrEn && paddr == `VIC_OFS_CORE) begin
      globalIrqEnable <= pwdata[`VIC_BIT_GIE];
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      stackPtr <= '0;
    end else if (take) begin
      stackPtr <= stackPtr + SPW'(1);
    end else if (returnFromIrq && stackPtr != '0) begin
      stackPtr <= stackPtr - SPW'(1);
    end
  end

  always_ff @(posedge ref_clk) begin
    if (take) begin
      stackMem[stackPtr[AW-1:0]] <= nextPc;
    end
  end

  assign next_resumeValid = returnFromIrq && stackPtr != '0;

  logic [PC_WIDTH-1:0] next_irqVector;
  always_comb begin
    unique case (1'b1)
      win[VIC_SRC_G1]: next_irqVector = PC_WIDTH'(`VIC_VEC_G1);
      win[VIC_SRC_G2]: next_irqVector = PC_WIDTH'(`VIC_VEC_G2);
      win[VIC_SRC_SER]: next_irqVector = PC_WIDTH'(`VIC_VEC_SER);
      win[VIC_SRC_UART]: next_irqVector = PC_WIDTH'(`VIC_VEC_UART);
      default: next_irqVector = '0;
    endcase
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      irqTake <= 1'b0;
      irqVector <= '0;
      resumeValid <= 1'b0;
      resumePc <= '0;
      state <= VIC_RUN;
    end else begin
      irqTake <= take;
      resumeValid <= next_resumeValid;
      if (take) begin
        irqVector <= next_irqVector;
        state <= VIC_SERVICE;
      end
      if (next_resumeValid) begin
        resumePc <= stackMem[AW'(stackPtr - SPW'(1))];
        if (stackPtr == SPW'(1)) begin
          state <= VIC_RUN;
        end
      end
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      wakeReq <= 1'b0;
    end else begin
      wakeReq <= (|ctrl3[7:4]) || (|grpLo[7:4]) || (|grpHi[7:4])
        || (|grpCt[7:4]);
    end
  end

  // Read data registered; status shows stack depth and service state
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      prdata <= '0;
    end else if (psel && !penable && !pwrite) begin
      unique case (paddr)
        `VIC_OFS_CTRL3: prdata <= {24'h000000, ctrl3};
        `VIC_OFS_GRP_PLO: prdata <= {24'h000000, grpLo};
        `VIC_OFS_GRP_PHI: prdata <= {24'h000000, grpHi};
        `VIC_OFS_GRP_CT: prdata <= {24'h000000, grpCt};
        `VIC_OFS_CORE: prdata <= {31'h00000000, globalIrqEnable};
        `VIC_OFS_STATUS: prdata <= {22'h000000, (state == VIC_SERVICE),
          stackFull, 8'(stackPtr)};
        default: prdata <= '0;
      endcase
    end
  end

  // Assertions
  gie_clear_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    irqTake |-> !globalIrqEnable) else $error("global enable not cleared");
  gie_block_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    !globalIrqEnable |=> !irqTake) else $error("take with global off");
  full_block_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    $past(stackFull) |-> !irqTake) else $error("take with stack full");
  small_zero_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    !LARGE_VARIANT |-> ctrl3[7] == 1'b0 && ctrl3[3] == 1'b0)
    else $error("small variant bits set");
  ser_set_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    serialEvent |=> ctrl3[`VIC_BIT_SER_F]) else $error("serial flag lost");
  // A match or a bus write of one on a member flag that is still clear makes a rise
  grp_set_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (|(timerMatch[11:8] & ~grpCt[7:4])) |=> ctrl3[`VIC_BIT_G2_F])
    else $error("group flag not set");
  member_keep_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (take && !wCt) |=> ($past(grpCt[7:4]) & ~grpCt[7:4]) == 4'h0)
    else $error("member flag changed");

  // Service clears: own vectors drop their flag, groups only the group
  own_clear_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (take && win[VIC_SRC_SER] && !serialEvent)
    |=> !ctrl3[`VIC_BIT_SER_F])
    else $error("serial flag kept on service");
  uart_clear_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (take && win[VIC_SRC_UART] && !uartEvent)
    |=> !ctrl3[`VIC_BIT_UART_F])
    else $error("uart flag kept on service");
  grp_clear_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (take && win[VIC_SRC_G1] && !grpNew[0])
    |=> !ctrl3[`VIC_BIT_G1_F])
    else $error("group flag kept on service");

  // Priority and vector selection
  prio_first_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (take && req[VIC_SRC_G1])
    |=> irqVector == PC_WIDTH'(`VIC_VEC_G1))
    else $error("group1 not preferred");
  ser_vector_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (take && win[VIC_SRC_SER])
    |=> irqVector == PC_WIDTH'(`VIC_VEC_SER))
    else $error("serial vector wrong");

  // Pending requests are not lost while blocked
  flag_keep_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (ctrl3[`VIC_BIT_SER_F] && !ctrl3[`VIC_BIT_SER_E] && !wCtrl3)
    |=> ctrl3[`VIC_BIT_SER_F])
    else $error("disabled flag dropped");
  pend_keep_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (ctrl3[`VIC_BIT_G2_F] && !wCtrl3 && !(take && win[VIC_SRC_G2]))
    |=> ctrl3[`VIC_BIT_G2_F])
    else $error("pending flag dropped");

  // Take timing against the core
  boundary_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    irqTake |-> $past(instrBoundary))
    else $error("take off boundary");
  single_take_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    irqTake |=> !irqTake)
    else $error("take repeated");

  // Return path
  pop_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (returnFromIrq && stackPtr != '0)
    |=> stackPtr == $past(stackPtr) - SPW'(1))
    else $error("no pop");
  resume_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (returnFromIrq && stackPtr != '0) |=> resumeValid)
    else $error("no resume");

  wake_grp_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (|timerMatch[3:0]) |=> ##1 wakeReq)
    else $error("no wake on timer");
  wake_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    serialEvent |=> ##1 wakeReq) else $error("no wake");
  push_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    take |=> stackPtr == $past(stackPtr) + SPW'(1))
    else $error("no push");
endmodule

/* testbench/vic_core_model.sv */
// Core-side partner: instruction boundaries, program counter, returns
`timescale 1ns/1ps
module vic_core_model #(
  parameter int PC_WIDTH = 12,
  parameter logic [PC_WIDTH-1:0] START_PC = 12'h100
) (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic irqTake,
  input wire logic [PC_WIDTH-1:0] irqVector,
  input wire logic [PC_WIDTH-1:0] resumePc,
  input wire logic resumeValid,
  input wire logic doReturn,
  output logic instrBoundary,
  output logic [PC_WIDTH-1:0] nextPc,
  output logic returnFromIrq
);
  // two-cycle instructions
  // Boundary only every other cycle, so a take can land only on every other edge
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      instrBoundary <= 1'b0;
    end else begin
      instrBoundary <= ~instrBoundary;
    end
  end
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      nextPc <= START_PC;
    end else if (irqTake) begin
      nextPc <= irqVector;
    end else if (resumeValid) begin
      nextPc <= resumePc;
    end
  end
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      returnFromIrq <= 1'b0;
    end else begin
      returnFromIrq <= doReturn;
    end
  end
endmodule

/* testbench/vectored_irq_controller_bench.sv */
// Self-checking bench for the vectored interrupt controller
`timescale 1ns/1ps
`include "vic_cfg.svh"
module vectored_irq_controller_bench import vic_pkg::*;;
  localparam logic [11:0] CTRL = `VIC_OFS_CTRL3;
  localparam logic [11:0] PLO = `VIC_OFS_GRP_PLO;
  localparam logic [11:0] CORE = `VIC_OFS_CORE;
  logic ref_clk = 1'b0;
  logic rst_n = 1'b0;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, err;
  logic [11:0] paddr = 12'h000, timerMatch = 12'h000;
  logic [31:0] pwdata = 32'h0, rd, prdata;
  logic [3:0] pstrb = 4'hF;
  logic serialEvent = 1'b0, uartEvent = 1'b0, doReturn = 1'b0;
  logic pready, pslverr, irqTake, resumeValid, stackFull, wakeReq;
  logic instrBoundary, returnFromIrq;
  logic [11:0] irqVector, resumePc, nextPc;
  int badCount = 0, checks = 0;
  logic [31:0] sPrdata, sRd;
  logic sPready, sPslverr, sIrqTake, sResumeValid, sStackFull, sWakeReq;
  logic [11:0] sIrqVector, sResumePc;

  // Small stack so the full condition is reached in a few takes
  vic_irq_ctrl #(.STACK_DEPTH(2)) dut_u (
    .ref_clk, .rst_n, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb,
    .prdata, .pready, .pslverr, .timerMatch, .serialEvent, .uartEvent,
    .instrBoundary, .nextPc, .returnFromIrq, .irqTake, .irqVector,
    .resumePc, .resumeValid, .stackFull, .wakeReq
  );
  // Small variant shares the bus and events; only its reads are compared
  vic_irq_ctrl #(.LARGE_VARIANT(1'b0), .STACK_DEPTH(2)) small_u (
    .ref_clk, .rst_n, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb,
    .prdata(sPrdata), .pready(sPready), .pslverr(sPslverr), .timerMatch,
    .serialEvent, .uartEvent, .instrBoundary, .nextPc, .returnFromIrq,
    .irqTake(sIrqTake), .irqVector(sIrqVector), .resumePc(sResumePc),
    .resumeValid(sResumeValid), .stackFull(sStackFull),
    .wakeReq(sWakeReq)
  );
  vic_core_model core_u (
    .ref_clk, .rst_n, .irqTake, .irqVector, .resumePc, .resumeValid,
    .doReturn, .instrBoundary, .nextPc, .returnFromIrq
  );

  initial begin
    forever #25 ref_clk = ~ref_clk;
  end

  task automatic summarize();
    $display("mismatches %0d of %0d checks", badCount, checks);
    if (badCount == 0 && checks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  task automatic check(input string what, input logic [31:0] seen, exp);
    checks++;
    if (seen !== exp) begin
      badCount++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic bound(input int n, input int lim);
    if (n >= lim) begin
      badCount++;
      summarize();
    end
  endtask

  task automatic apb(input logic wr, input logic [11:0] a,
                     input logic [31:0] d);
    int n;
    n = 0;
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge ref_clk);
    penable <= 1'b1;
    do begin
      @(posedge ref_clk);
      n++;
    end while (pready !== 1'b1 && n < 16);
    rd = prdata;
    sRd = sPrdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    // Idle edge keeps back-to-back calls from driving psel twice at once
    @(posedge ref_clk);
    bound(n, 16);
  endtask

  task automatic fire(input logic [11:0] tm, input logic s, u);
    timerMatch <= tm;
    serialEvent <= s;
    uartEvent <= u;
    @(posedge ref_clk);
    timerMatch <= 12'h000;
    serialEvent <= 1'b0;
    uartEvent <= 1'b0;
    @(posedge ref_clk);
  endtask

  // The take pulse lasts one cycle, so it is watched at falling edges
  task automatic expectTake(input logic [11:0] vec);
    int n;
    n = 0;
    do begin
      @(negedge ref_clk);
      n++;
    end while (irqTake !== 1'b1 && n < 40);
    bound(n, 40);
    check("vector", 32'(irqVector), 32'(vec));
    @(posedge ref_clk);
  endtask

  task automatic expectNoTake();
    int seen;
    seen = 0;
    repeat (12) begin
      @(negedge ref_clk);
      if (irqTake === 1'b1) seen++;
    end
    @(posedge ref_clk);
    check("no take", seen, 32'h0);
  endtask

  task automatic ret(input logic [11:0] exp);
    int n;
    n = 0;
    doReturn <= 1'b1;
    @(posedge ref_clk);
    doReturn <= 1'b0;
    do begin
      @(negedge ref_clk);
      n++;
    end while (resumeValid !== 1'b1 && n < 8);
    bound(n, 8);
    check("resume pc", 32'(resumePc), 32'(exp));
    @(posedge ref_clk);
  endtask

  task automatic tRegs();
    for (int i = 0; i < 6; i++) begin
      apb(1'b0, 12'(i * 4), 32'h0);
      check("reset value", rd, 32'h0);
    end
    apb(1'b0, 12'h018, 32'h0);
    check("unmapped", {31'h0, err}, 32'h1);
    for (int i = 0; i < 4; i++) begin
      apb(1'b1, 12'(i * 4), 32'hFF);
      // Wake is registered one edge after the flag
      @(posedge ref_clk);
      check("wake", {31'h0, wakeReq}, 32'h1);
      apb(1'b0, 12'(i * 4), 32'h0);
      check("all bits", rd, 32'hFF);
      if (i == 0) check("small variant", sRd, 32'h77);
      apb(1'b1, 12'(i * 4), 32'h0);
    end
    apb(1'b1, CTRL, 32'h0);
    @(posedge ref_clk);
    check("no wake", {31'h0, wakeReq}, 32'h0);
  endtask

  task automatic tService();
    fire(12'h00F, 1'b1, 1'b1);
    apb(1'b0, PLO, 32'h0);
    check("event flags", rd, 32'hF0);
    apb(1'b0, CTRL, 32'h0);
    check("group flag", rd, 32'hD0);
    apb(1'b1, CORE, 32'h1);
    expectNoTake();
    apb(1'b1, CORE, 32'h0);
    apb(1'b1, CTRL, 32'hDF);
    apb(1'b1, PLO, 32'hFF);
    expectNoTake();
    apb(1'b1, CORE, 32'h1);
    expectTake(`VIC_VEC_G1);
    apb(1'b0, CORE, 32'h0);
    check("global off", rd, 32'h0);
    fire(12'hF00, 1'b0, 1'b0);
    apb(1'b0, CTRL, 32'h0);
    check("pending", rd, 32'hEF);
    apb(1'b0, PLO, 32'h0);
    check("members kept", rd, 32'hFF);
    // Software re-enables to nest; group2 has no enabled member
    apb(1'b1, CORE, 32'h1);
    expectTake(`VIC_VEC_SER);
    apb(1'b0, CTRL, 32'h0);
    check("own clear", rd, 32'hAF);
    check("full", {31'h0, stackFull}, 32'h1);
    apb(1'b1, CORE, 32'h1);
    expectNoTake();
    apb(1'b1, CORE, 32'h0);
    ret(`VIC_VEC_G1);
    apb(1'b1, CORE, 32'h1);
    expectTake(`VIC_VEC_UART);
    apb(1'b1, CORE, 32'h0);
    apb(1'b0, CTRL, 32'h0);
    check("uart clear", rd, 32'h2F);
    ret(`VIC_VEC_G1);
    ret(12'h100);
    check("not full", {31'h0, stackFull}, 32'h0);
  endtask

  initial begin
    repeat (4) @(posedge ref_clk);
    rst_n <= 1'b1;
    @(posedge ref_clk);
    tRegs();
    tService();
    summarize();
  end
endmodule
